/* File: logic/lhi_cfg.svh */
`ifndef LHI_CFG_SVH
`define LHI_CFG_SVH

// printed register offsets are word indices; byte address is four times
`define LHI_IDX_LOSS_STAT  14'h0B12
`define LHI_IDX_LOSS_EN    14'h0B13
`define LHI_IDX_DL2_STAT   14'h0B16
`define LHI_IDX_DL2_MASK   14'h0B1F

`define LHI_ADDR_LOSS_STAT {`LHI_IDX_LOSS_STAT, 2'b00}
`define LHI_ADDR_LOSS_EN   {`LHI_IDX_LOSS_EN, 2'b00}
`define LHI_ADDR_DL2_STAT  {`LHI_IDX_DL2_STAT, 2'b00}
`define LHI_ADDR_DL2_MASK  {`LHI_IDX_DL2_MASK, 2'b00}

// field positions inside the 8-bit registers
`define LHI_BIT_LOSS       3
`define LHI_BIT_KIND       7
`define LHI_BIT_TX_BEGUN   6
`define LHI_BIT_RX_BEGUN   5
`define LHI_BIT_TX_DONE    4

// reset values
`define LHI_RST_LOSS_EN    8'h08
`define LHI_RST_DL2_MASK   8'h00
`define LHI_RST_FLAGS      4'h0

`endif

/* File: logic/lhi_pkg.sv */
package lhi_pkg;

  typedef enum logic [2:0] {
    LHI_REG_NONE      = 3'b000,
    LHI_REG_LOSS_STAT = 3'b001,
    LHI_REG_LOSS_EN   = 3'b010,
    LHI_REG_DL2_STAT  = 3'b011,
    LHI_REG_DL2_MASK  = 3'b100
  } lhi_reg_t;

  // indications from the receive framer and the second data link pair
  typedef struct packed {
    logic los_level;
    logic msg_kind;
    logic tx_start;
    logic rx_start;
    logic tx_end;
  } lhi_evt_t;

  // decoded bus access
  typedef struct packed {
    logic     setup;
    logic     done;
    logic     wr;
    logic     hit;
    lhi_reg_t id;
  } lhi_acc_t;

endpackage : lhi_pkg

/* File: logic/lhi_apb_dec.sv */
`timescale 1ns/1ns
`include "lhi_cfg.svh"

module lhi_apb_dec (
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [15:0] paddr_i,
  output lhi_pkg::lhi_acc_t acc_o
);

  wire logic is_loss_stat;
  wire logic is_loss_en;
  wire logic is_dl2_stat;
  wire logic is_dl2_mask;

  assign is_loss_stat = (paddr_i == `LHI_ADDR_LOSS_STAT);
  assign is_loss_en   = (paddr_i == `LHI_ADDR_LOSS_EN);
  assign is_dl2_stat  = (paddr_i == `LHI_ADDR_DL2_STAT);
  assign is_dl2_mask  = (paddr_i == `LHI_ADDR_DL2_MASK);

  assign acc_o.setup = psel_i & ~penable_i;
  assign acc_o.done  = psel_i & penable_i;
  assign acc_o.wr    = pwrite_i;
  assign acc_o.hit   = is_loss_stat | is_loss_en | is_dl2_stat | is_dl2_mask;
  assign acc_o.id    = is_loss_stat ? lhi_pkg::LHI_REG_LOSS_STAT :
                       is_loss_en   ? lhi_pkg::LHI_REG_LOSS_EN   :
                       is_dl2_stat  ? lhi_pkg::LHI_REG_DL2_STAT  :
                       is_dl2_mask  ? lhi_pkg::LHI_REG_DL2_MASK  :
                                      lhi_pkg::LHI_REG_NONE;

endmodule : lhi_apb_dec

/* File: logic/lhi_flags.sv */
`timescale 1ns/1ns
`include "lhi_cfg.svh"

module lhi_flags (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [3:0] set_i,
  input  wire logic [3:0] clr_i,
  output logic      [3:0] flag_o
);

  localparam logic [3:0] RST_FLAGS = `LHI_RST_FLAGS;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_flag
      wire logic next_flag;
      // a set in the clearing cycle survives
      assign next_flag = set_i[gi] | (flag_o[gi] & ~clr_i[gi]);
      always_ff @(posedge clk_i)
      begin
        if (!nrst_i)
          flag_o[gi] <= RST_FLAGS[gi];
        else
          flag_o[gi] <= next_flag;
      end
    end
  endgenerate

endmodule : lhi_flags

/* File: logic/lhi_top.sv */
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`include "lhi_cfg.svh"

module lhi_top (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [15:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire lhi_pkg::lhi_evt_t evt_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   irq_o
);

  localparam logic [7:0] RST_LOSS_EN = `LHI_RST_LOSS_EN;

  lhi_pkg::lhi_acc_t acc;
  logic        [3:0] flags;
  logic        [3:0] snap;
  logic              los_prev;
  logic              los_primed;
  logic              loss_off;
  logic        [2:0] dl2_mask;

  wire logic       los_rise;
  wire logic       los_fall;
  wire logic [3:0] set_vec;
  wire logic [3:0] clr_rd;
  wire logic [3:0] clr_wr;
  wire logic       rd_done;
  wire logic       wr_done;
  wire logic       rd_setup;
  wire logic       loss_change_flag;
  wire logic       tx_message_begun;
  wire logic       rx_message_begun;
  wire logic       tx_message_done;
  wire logic       received_message_kind;
  wire logic       loss_change_irq_on;
  wire logic [7:0] rd_loss_stat;
  wire logic [7:0] rd_loss_en;
  wire logic [7:0] rd_dl2_stat;
  wire logic [7:0] rd_dl2_mask;
  wire logic [7:0] rd_mux;
  wire logic       next_irq;

  lhi_apb_dec u_dec (
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .acc_o     (acc)
  );

  assign rd_setup = acc.setup & ~acc.wr;
  assign rd_done  = acc.done & ~acc.wr;
  assign wr_done  = acc.done & acc.wr;

  // level from the receive framer; edges only count once primed
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      los_prev   <= 1'b0;
      los_primed <= 1'b0;
    end
    else
    begin
      los_prev   <= evt_i.los_level;
      los_primed <= 1'b1;
    end
  end

  assign los_rise = los_primed & evt_i.los_level & ~los_prev;
  assign los_fall = los_primed & ~evt_i.los_level & los_prev;

  // flag order: 0 loss, 1 tx done, 2 rx begun, 3 tx begun
  assign set_vec = {evt_i.tx_start,
                    evt_i.rx_start,
                    evt_i.tx_end,
                    los_rise | los_fall};

  // a read clears only what the read returned
  assign clr_rd = (rd_done && acc.id == lhi_pkg::LHI_REG_LOSS_STAT) ?
                    {3'b000, snap[0]} :
                  (rd_done && acc.id == lhi_pkg::LHI_REG_DL2_STAT) ?
                    {snap[3:1], 1'b0} :
                    4'h0;

  // writing a one also clears
  assign clr_wr = (wr_done && acc.id == lhi_pkg::LHI_REG_LOSS_STAT) ?
                    {3'b000, pwdata_i[`LHI_BIT_LOSS]} :
                  (wr_done && acc.id == lhi_pkg::LHI_REG_DL2_STAT) ?
                    {pwdata_i[`LHI_BIT_TX_BEGUN],
                     pwdata_i[`LHI_BIT_RX_BEGUN],
                     pwdata_i[`LHI_BIT_TX_DONE], 1'b0} :
                    4'h0;

  lhi_flags u_flags (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec),
    .clr_i  (clr_rd | clr_wr),
    .flag_o (flags)
  );

  assign loss_change_flag      = flags[0];
  assign tx_message_done       = flags[1];
  assign rx_message_begun      = flags[2];
  assign tx_message_begun      = flags[3];
  assign received_message_kind = evt_i.msg_kind;
  assign loss_change_irq_on    = ~loss_off;

  // control registers
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      loss_off <= RST_LOSS_EN[`LHI_BIT_LOSS];
      dl2_mask <= 3'(`LHI_RST_DL2_MASK >> `LHI_BIT_TX_DONE);
    end
    else if (wr_done)
    begin
      if (acc.id == lhi_pkg::LHI_REG_LOSS_EN)
        loss_off <= pwdata_i[`LHI_BIT_LOSS];
      if (acc.id == lhi_pkg::LHI_REG_DL2_MASK)
        dl2_mask <= pwdata_i[`LHI_BIT_TX_BEGUN:`LHI_BIT_TX_DONE];
    end
  end

  // register read images, reserved bits read as zero
  assign rd_loss_stat = {4'h0, loss_change_flag, 3'b000};
  assign rd_loss_en   = {4'h0, loss_off, 3'b000};
  assign rd_dl2_stat  = {received_message_kind,
                         tx_message_begun,
                         rx_message_begun,
                         tx_message_done, 4'h0};
  assign rd_dl2_mask  = {1'b0, dl2_mask, 4'h0};

  assign rd_mux = (acc.id == lhi_pkg::LHI_REG_LOSS_STAT) ? rd_loss_stat :
                  (acc.id == lhi_pkg::LHI_REG_LOSS_EN)   ? rd_loss_en   :
                  (acc.id == lhi_pkg::LHI_REG_DL2_STAT)  ? rd_dl2_stat  :
                  (acc.id == lhi_pkg::LHI_REG_DL2_MASK)  ? rd_dl2_mask  :
                                                           8'h00;

  // read data is captured in the setup cycle, along with the flags
  // it shows, so the access edge clears exactly what was returned
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      prdata_o <= 32'h0000_0000;
      snap     <= 4'h0;
    end
    else if (rd_setup)
    begin
      prdata_o <= {24'h00_0000, rd_mux};
      snap     <= flags;
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = acc.done & ~acc.hit;

  assign next_irq = (loss_change_flag & loss_change_irq_on) |
                    (|(flags[3:1] & dl2_mask));

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      irq_o <= 1'b0;
    else
      irq_o <= next_irq;
  end

endmodule : lhi_top

/* File: dv/lhi_top_assertions.sv */
`timescale 1ns/1ns
`include "lhi_cfg.svh"

module lhi_top_assertions (
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [15:0]       paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire lhi_pkg::lhi_evt_t evt_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  wire su    = psel_i && !penable_i && !pwrite_i;
  wire ac    = psel_i && penable_i;
  wire rd_dl = su && paddr_i == `LHI_ADDR_DL2_STAT;
  wire rd_ls = su && paddr_i == `LHI_ADDR_LOSS_STAT;
  wire hit   = paddr_i inside {`LHI_ADDR_LOSS_STAT, `LHI_ADDR_LOSS_EN,
                               `LHI_ADDR_DL2_STAT, `LHI_ADDR_DL2_MASK};
  wire quiet = !(|evt_i[2:0]);
  wire ac_dl = ac && paddr_i == `LHI_ADDR_DL2_STAT;
  wire ac_ls = ac && paddr_i == `LHI_ADDR_LOSS_STAT;
  ready_high_a: assert property (pready_o)
    else $error("pready low");
  bad_err_a: assert property (ac && !hit |-> pslverr_o)
    else $error("no error on unmapped access");
  bad_zero_a: assert property (su && !hit |=> prdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  kind_live_a: assert property (
    rd_dl |=> prdata_o[7] == $past(evt_i.msg_kind))
    else $error("message kind wrong");
  tx_begun_a: assert property (
    evt_i.tx_start ##1 (!ac_dl)[*3] ##1 rd_dl |=> prdata_o[6])
    else $error("tx start flag missing");
  rx_begun_a: assert property (
    evt_i.rx_start ##1 (!ac_dl)[*3] ##1 rd_dl |=> prdata_o[5])
    else $error("rx start flag missing");
  tx_done_a: assert property (
    evt_i.tx_end ##1 (!ac_dl)[*3] ##1 rd_dl |=> prdata_o[4])
    else $error("tx end flag missing");
  loss_chg_a: assert property (
    $changed(evt_i.los_level) ##1 (!ac_ls)[*3] ##1 rd_ls |=> prdata_o[3])
    else $error("loss change flag missing");
  read_clr_a: assert property (
    ac_dl && !pwrite_i && quiet && $past(quiet) ##1 quiet ##1 rd_dl
    |=> prdata_o[6:4] == 3'h0)
    else $error("flags not cleared by read");
  cover property ($rose(irq_o));
  cover property (pslverr_o);
  cover property (rd_dl ##1 prdata_o[6]);
endmodule : lhi_top_assertions

bind lhi_top lhi_top_assertions lhi_top_assertions_inst (.clk_i(clk_i),
  .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .evt_i(evt_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .irq_o(irq_o));

/* File: dv/tb_lhi_top.sv */
`timescale 1ns/1ns
`include "lhi_cfg.svh"

module tb_lhi_top;
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              psel, penable, pwrite, pready, pslverr, irq, err;
  logic [15:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [7:0]        q;
  lhi_pkg::lhi_evt_t evt;
  int                n_mismatch = 0;
  int                num_checks = 0;
  logic              timed_out = 1'b0;
  always #5 clk_i = ~clk_i;
  lhi_top lhi_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .evt_i(evt), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      $display("mismatch %0t bus timeout", $time);
      timed_out = 1'b1;
    end
    q       = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic pulse(input int b);
    @(posedge clk_i);
    evt[b] <= 1'b1;
    @(posedge clk_i);
    evt[b] <= 1'b0;
  endtask : pulse
  task automatic t_reset;
    rd(`LHI_ADDR_LOSS_EN, 8'h08);
    rd(`LHI_ADDR_DL2_MASK, 8'h00);
    rd(`LHI_ADDR_LOSS_STAT, 8'h00);
    rd(`LHI_ADDR_DL2_STAT, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_los;
    apb(1'b1, `LHI_ADDR_LOSS_EN, 8'h00);
    evt.los_level <= 1'b1;
    tick(3);
    chk({7'h00, irq}, 8'h01);
    rd(`LHI_ADDR_LOSS_STAT, 8'h08);
    rd(`LHI_ADDR_LOSS_STAT, 8'h00);
    tick(2);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk_i);
    evt.los_level <= 1'b0;
    tick(3);
    chk({7'h00, irq}, 8'h01);
    rd(`LHI_ADDR_LOSS_STAT, 8'h08);
    apb(1'b1, `LHI_ADDR_LOSS_EN, 8'h08);
    evt.los_level <= 1'b1;
    tick(3);
    chk({7'h00, irq}, 8'h00);
    rd(`LHI_ADDR_LOSS_STAT, 8'h08);
    $display("test loss done");
  endtask : t_los
  task automatic t_dl;
    apb(1'b1, `LHI_ADDR_DL2_MASK, 8'h70);
    evt.msg_kind <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      // host side: tx start always comes before tx end
      pulse(2 - i);
      tick(2);
      chk({7'h00, irq}, 8'h01);
      rd(`LHI_ADDR_DL2_STAT, 8'h80 | (8'h40 >> i));
      rd(`LHI_ADDR_DL2_STAT, 8'h80);
    end
    apb(1'b1, `LHI_ADDR_DL2_MASK, 8'h00);
    evt.msg_kind <= 1'b0;
    pulse(2);
    tick(2);
    chk({7'h00, irq}, 8'h00);
    apb(1'b1, `LHI_ADDR_DL2_STAT, 8'h80);
    rd(`LHI_ADDR_DL2_STAT, 8'h40);
    pulse(0);
    tick(2);
    // writing a one clears the flag too
    apb(1'b1, `LHI_ADDR_DL2_STAT, 8'h10);
    rd(`LHI_ADDR_DL2_STAT, 8'h00);
    $display("test data link done");
  endtask : t_dl
  task automatic t_bad;
    apb(1'b1, 16'h0100, 8'hFF);
    chk({7'h00, err}, 8'h01);
    rd(16'h0100, 8'h00);
    rd(`LHI_ADDR_LOSS_EN, 8'h08);
    $display("test unmapped done");
  endtask : t_bad
  task automatic t_rst2;
    apb(1'b1, `LHI_ADDR_LOSS_EN, 8'h00);
    // loss level stays high across reset: no event after release
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(`LHI_ADDR_LOSS_STAT, 8'h00);
    rd(`LHI_ADDR_LOSS_EN, 8'h08);
    chk({7'h00, irq}, 8'h00);
    $display("test mid reset done");
  endtask : t_rst2
  initial
  begin
    {psel, penable, pwrite} = 3'b000;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    evt = '0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    fork
      begin
        t_reset();
        t_los();
        t_dl();
        t_bad();
        t_rst2();
      end
      wait (timed_out);
    join_any
    summarize();
  end
endmodule : tb_lhi_top
